// File: rdw_engine.sv
// Receive descriptor write-back engine: walks a linked descriptor queue,
// stores received bytes and writes back lengths, offsets and flags.
// Assumes an APB master, a word memory with a req/ack handshake, and a
// MAC byte stream that holds each byte until pkt_ready takes it.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - Non-zero start offset shifts data into buffer and is copied to offset field.
// - Start offset applies only to first buffer; later buffers get a zero offset field.
// - Buffer length holds physical size, then engine writes count of valid bytes.
// - Packet length starts zero; engine writes whole packet count in first descriptor.
// - Engine sets first flag on first buffer, last flag on final buffer.
// - Ownership cleared only in first descriptor after whole packet is done, or in teardown descriptor.
// - Null next pointer at packet end sets end-of-queue flag and halts channel.
// - Teardown marks first free descriptor and stops all queue processing.
// - First descriptor flags a stored packet that includes its CRC.
// - Kept overlong frame with CRC, code or alignment error is flagged jabber.
// - Oversized frame with no CRC, code or alignment error, kept by error-frame keep bit, gets the oversize flag.
// - Fragment kept by error-frame keep bit gets the fragment flag.
// - Undersized frame kept by short-frame keep bit gets the undersized flag.
// - Control frame kept by control-frame keep bit gets the control flag.
// - Overrun-aborted packet always gets the overrun flag.
// - Kept frame with code error gets the code-error flag.
// - Kept frame with alignment error gets the alignment-error flag.
// - Offset and length share one word, flags and packet length another.
// - Kept frame with bad CRC gets the CRC-error flag.
// - Frame kept only by all-frames keep bit gets the address-miss flag.
// - Engine follows next pointer, zero ends queue, pointer never written.
module rdw_engine (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Descriptor and buffer memory master
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [3:0] mem_be,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // Received byte stream from the MAC
  input wire logic pkt_valid,
  input wire logic [7:0] pkt_byte,
  input wire logic pkt_last,
  output logic pkt_ready,
  // Frame status, valid with the last byte
  input wire logic pkt_crc_included,
  input wire logic pkt_crc_err,
  input wire logic pkt_code_err,
  input wire logic pkt_align_err,
  input wire logic pkt_fragment,
  input wire logic pkt_undersized,
  input wire logic pkt_control,
  input wire logic pkt_overrun,
  input wire logic pkt_addr_miss,
  // Channel state
  output logic chan_running
);

  typedef struct packed {
    rdw_pkg::rdw_state_t st;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [15:0] start_off;
    logic [3:0] keep;
    logic [15:0] max_len;
    logic running;
    logic td_pending;
    logic td_done;
    logic mem_req;
    logic mem_we;
    logic [31:0] mem_addr;
    logic [3:0] mem_be;
    logic [31:0] mem_wdata;
    logic pkt_ready;
    logic [31:0] cur;
    logic [31:0] next_ptr;
    logic [31:0] buf_ptr;
    logic [31:0] wr_ptr;
    logic [31:0] first_addr;
    logic [15:0] cur_off;
    logic [15:0] cap;
    logic [15:0] fill;
    logic [15:0] pkt_len;
    logic is_first;
    logic in_pkt;
    logic done;
    logic last_seen;
    logic trunc;
    logic [8:0] stat;
  } rdw_regs_t;

  rdw_regs_t s_reg;
  rdw_regs_t s_next;

  // Byte-lane write strobe for a byte address
  function automatic logic [3:0] lane_be(input logic [31:0] addr);
    lane_be = 4'h1 << addr[1:0];
  endfunction

  // Flag word for the first descriptor of a finished packet
  function automatic logic [31:0] first_word(input rdw_regs_t r);
    logic err;
    logic over;
    first_word = 32'h0000_0000;
    err = r.stat[1] | r.stat[2] | r.stat[3];
    over = r.pkt_len > r.max_len;
    first_word[rdw_pkg::FLG_FIRST] = 1'b1;
    first_word[rdw_pkg::FLG_LAST] = r.is_first;
    first_word[rdw_pkg::FLG_OWNERSHIP_FLAG] = 1'b0;
    first_word[rdw_pkg::FLG_EOQ] = r.is_first && (r.next_ptr == 32'h0000_0000);
    first_word[rdw_pkg::FLG_CRC_INC] = r.stat[0];
    first_word[rdw_pkg::FLG_JABBER] = r.keep[rdw_pkg::KEEP_ERROR] & over & err;
    first_word[rdw_pkg::FLG_OVERSIZE] = r.keep[rdw_pkg::KEEP_ERROR] & over & ~err;
    first_word[rdw_pkg::FLG_FRAGMENT] = r.keep[rdw_pkg::KEEP_ERROR] & r.stat[4];
    first_word[rdw_pkg::FLG_UNDERSIZED] = r.keep[rdw_pkg::KEEP_SHORT] & r.stat[5];
    first_word[rdw_pkg::FLG_CONTROL] = r.keep[rdw_pkg::KEEP_CONTROL] & r.stat[6];
    first_word[rdw_pkg::FLG_OVERRUN] = r.stat[7] | r.trunc;
    first_word[rdw_pkg::FLG_CODE_ERR] = r.keep[rdw_pkg::KEEP_ERROR] & r.stat[2];
    first_word[rdw_pkg::FLG_ALIGN_ERR] = r.keep[rdw_pkg::KEEP_ERROR] & r.stat[3];
    first_word[rdw_pkg::FLG_CRC_ERR] = r.keep[rdw_pkg::KEEP_ERROR] & r.stat[1];
    first_word[rdw_pkg::FLG_ADDR_MISS] = r.keep[rdw_pkg::KEEP_ALL] & r.stat[8];
    first_word[15:0] = r.pkt_len;
  endfunction

  always_comb begin
    logic apb_wr;
    logic apb_rd;
    logic full;
    apb_wr = psel && penable && s_reg.pready && pwrite;
    apb_rd = psel && penable && !s_reg.pready && !pwrite;
    full = 1'b0;
    s_next = s_reg;

    // Register port: one wait cycle, so read data leaves a flop
    s_next.pready = psel && penable && !s_reg.pready;
    s_next.pslverr = 1'b0;
    if (psel && penable && !s_reg.pready) begin
      s_next.pslverr = paddr > rdw_pkg::REG_CUR_DESC || paddr[1:0] != 2'b00;
    end
    if (apb_rd) begin
      if (paddr == rdw_pkg::REG_HEAD_PTR) begin
        s_next.prdata = s_reg.cur;
      end else if (paddr == rdw_pkg::REG_START_OFFSET) begin
        s_next.prdata = {16'h0000, s_reg.start_off};
      end else if (paddr == rdw_pkg::REG_FILTER_ENABLE) begin
        s_next.prdata = {28'h0000000, s_reg.keep};
      end else if (paddr == rdw_pkg::REG_MAX_LEN) begin
        s_next.prdata = {16'h0000, s_reg.max_len};
      end else if (paddr == rdw_pkg::REG_STATUS) begin
        s_next.prdata = {30'h00000000, s_reg.td_done, s_reg.running};
      end else if (paddr == rdw_pkg::REG_CUR_DESC) begin
        s_next.prdata = s_reg.cur;
      end else begin
        s_next.prdata = 32'h0000_0000;
      end
    end
    if (apb_wr) begin
      if (paddr == rdw_pkg::REG_START_OFFSET) begin
        s_next.start_off = pwdata[15:0];
      end else if (paddr == rdw_pkg::REG_FILTER_ENABLE) begin
        s_next.keep = pwdata[3:0];
      end else if (paddr == rdw_pkg::REG_MAX_LEN) begin
        s_next.max_len = pwdata[15:0];
      end else if (paddr == rdw_pkg::REG_TEARDOWN && pwdata[0]) begin
        s_next.td_pending = 1'b1;
      end else if (paddr == rdw_pkg::REG_STATUS && pwdata[rdw_pkg::STAT_TD_DONE]) begin
        s_next.td_done = 1'b0;
      end
    end

    case (s_reg.st)
      rdw_pkg::ST_IDLE: begin
        s_next.pkt_ready = 1'b0;
        if (s_reg.td_pending) begin
          // Nothing queued, so the teardown finishes at once
          s_next.td_pending = 1'b0;
          s_next.td_done = 1'b1;
        end else if (apb_wr && paddr == rdw_pkg::REG_HEAD_PTR) begin
          s_next.cur = pwdata;
          s_next.running = 1'b1;
          s_next.st = rdw_pkg::ST_RD_NEXT;
        end
      end
      rdw_pkg::ST_RD_NEXT: begin
        if (!s_reg.mem_req) begin
          s_next.mem_req = 1'b1;
          s_next.mem_we = 1'b0;
          s_next.mem_addr = s_reg.cur + rdw_pkg::DESC_NEXT;
          s_next.mem_be = 4'hF;
        end else if (mem_ack) begin
          s_next.mem_req = 1'b0;
          s_next.next_ptr = mem_rdata;
          s_next.st = rdw_pkg::ST_RD_BUF;
        end
      end
      rdw_pkg::ST_RD_BUF: begin
        if (!s_reg.mem_req) begin
          s_next.mem_req = 1'b1;
          s_next.mem_addr = s_reg.cur + rdw_pkg::DESC_BUF;
        end else if (mem_ack) begin
          s_next.mem_req = 1'b0;
          s_next.buf_ptr = mem_rdata;
          s_next.st = rdw_pkg::ST_RD_LEN;
        end
      end
      rdw_pkg::ST_RD_LEN: begin
        if (!s_reg.mem_req) begin
          s_next.mem_req = 1'b1;
          s_next.mem_addr = s_reg.cur + rdw_pkg::DESC_OFFLEN;
        end else if (mem_ack) begin
          s_next.mem_req = 1'b0;
          s_next.is_first = !s_reg.in_pkt;
          // Offset only for the first buffer of a packet
          s_next.cur_off = s_reg.in_pkt ? 16'h0000 : s_reg.start_off;
          s_next.cap = mem_rdata[15:0] - (s_reg.in_pkt ? 16'h0000 : s_reg.start_off);
          s_next.wr_ptr = s_reg.buf_ptr + {16'h0000, s_reg.in_pkt ? 16'h0000 : s_reg.start_off};
          s_next.fill = 16'h0000;
          if (s_reg.td_pending && !s_reg.in_pkt) begin
            s_next.st = rdw_pkg::ST_TEARDOWN;
          end else begin
            s_next.pkt_ready = 1'b1;
            s_next.st = rdw_pkg::ST_WAIT_BYTE;
          end
        end
      end
      rdw_pkg::ST_WAIT_BYTE: begin
        if (pkt_valid && s_reg.pkt_ready) begin
          s_next.pkt_ready = 1'b0;
          s_next.in_pkt = 1'b1;
          s_next.last_seen = pkt_last;
          s_next.mem_req = 1'b1;
          s_next.mem_we = 1'b1;
          s_next.mem_addr = {s_reg.wr_ptr[31:2], 2'b00};
          s_next.mem_be = lane_be(s_reg.wr_ptr);
          s_next.mem_wdata = {4{pkt_byte}};
          if (pkt_last) begin
            s_next.stat = {pkt_addr_miss, pkt_overrun, pkt_control, pkt_undersized,
              pkt_fragment, pkt_align_err, pkt_code_err, pkt_crc_err, pkt_crc_included};
          end
          s_next.st = rdw_pkg::ST_WR_BYTE;
        end else if (s_reg.td_pending && !s_reg.in_pkt) begin
          // Teardown waits for a packet boundary
          s_next.pkt_ready = 1'b0;
          s_next.st = rdw_pkg::ST_TEARDOWN;
        end
      end
      rdw_pkg::ST_WR_BYTE: begin
        if (mem_ack) begin
          s_next.mem_req = 1'b0;
          s_next.wr_ptr = s_reg.wr_ptr + 32'h0000_0001;
          s_next.fill = s_reg.fill + 16'h0001;
          s_next.pkt_len = s_reg.pkt_len + 16'h0001;
          full = (s_reg.fill + 16'h0001) == s_reg.cap;
          if (s_reg.last_seen) begin
            s_next.done = 1'b1;
            s_next.st = rdw_pkg::ST_WB_LEN;
          end else if (full) begin
            // Buffer full mid-packet: a null next pointer closes it here as an overrun
            s_next.done = s_reg.next_ptr == 32'h0000_0000;
            s_next.trunc = s_reg.next_ptr == 32'h0000_0000;
            s_next.st = rdw_pkg::ST_WB_LEN;
          end else begin
            s_next.pkt_ready = 1'b1;
            s_next.st = rdw_pkg::ST_WAIT_BYTE;
          end
        end
      end
      rdw_pkg::ST_WB_LEN: begin
        if (!s_reg.mem_req) begin
          s_next.mem_req = 1'b1;
          s_next.mem_we = 1'b1;
          s_next.mem_be = 4'hF;
          s_next.mem_addr = s_reg.cur + rdw_pkg::DESC_OFFLEN;
          s_next.mem_wdata = {s_reg.cur_off, s_reg.fill};
        end else if (mem_ack) begin
          s_next.mem_req = 1'b0;
          if (s_reg.is_first) begin
            s_next.first_addr = s_reg.cur;
          end
          if (!s_reg.is_first) begin
            s_next.st = rdw_pkg::ST_WB_FLAGS;
          end else if (s_reg.done) begin
            s_next.st = rdw_pkg::ST_WB_FIRST;
          end else begin
            s_next.cur = s_reg.next_ptr;
            s_next.st = rdw_pkg::ST_RD_NEXT;
          end
        end
      end
      rdw_pkg::ST_WB_FLAGS: begin
        if (!s_reg.mem_req) begin
          // Later buffers keep ownership set until the first one releases all
          s_next.mem_req = 1'b1;
          s_next.mem_addr = s_reg.cur + rdw_pkg::DESC_FLAGLEN;
          s_next.mem_wdata = 32'h0000_0000;
          s_next.mem_wdata[rdw_pkg::FLG_OWNERSHIP_FLAG] = 1'b1;
          s_next.mem_wdata[rdw_pkg::FLG_LAST] = s_reg.done;
          s_next.mem_wdata[rdw_pkg::FLG_EOQ] =
            s_reg.done && (s_reg.next_ptr == 32'h0000_0000);
        end else if (mem_ack) begin
          s_next.mem_req = 1'b0;
          if (s_reg.done) begin
            s_next.st = rdw_pkg::ST_WB_FIRST;
          end else begin
            s_next.cur = s_reg.next_ptr;
            s_next.st = rdw_pkg::ST_RD_NEXT;
          end
        end
      end
      rdw_pkg::ST_WB_FIRST: begin
        if (!s_reg.mem_req) begin
          s_next.mem_req = 1'b1;
          s_next.mem_addr = s_reg.first_addr + rdw_pkg::DESC_FLAGLEN;
          s_next.mem_wdata = first_word(s_reg);
        end else if (mem_ack) begin
          s_next.mem_req = 1'b0;
          s_next.in_pkt = 1'b0;
          s_next.done = 1'b0;
          s_next.trunc = 1'b0;
          s_next.pkt_len = 16'h0000;
          s_next.stat = 9'h000;
          if (s_reg.next_ptr == 32'h0000_0000) begin
            s_next.running = 1'b0;
            s_next.st = rdw_pkg::ST_IDLE;
          end else begin
            s_next.cur = s_reg.next_ptr;
            s_next.st = rdw_pkg::ST_RD_NEXT;
          end
        end
      end
      rdw_pkg::ST_TEARDOWN: begin
        if (!s_reg.mem_req) begin
          s_next.mem_req = 1'b1;
          s_next.mem_we = 1'b1;
          s_next.mem_be = 4'hF;
          s_next.mem_addr = s_reg.cur + rdw_pkg::DESC_FLAGLEN;
          s_next.mem_wdata = 32'h0000_0000;
          s_next.mem_wdata[rdw_pkg::FLG_TEARDOWN] = 1'b1;
        end else if (mem_ack) begin
          s_next.mem_req = 1'b0;
          s_next.td_pending = 1'b0;
          s_next.td_done = 1'b1;
          s_next.running = 1'b0;
          s_next.st = rdw_pkg::ST_IDLE;
        end
      end
      default: begin
        s_next.st = rdw_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      s_reg <= '0;
      s_reg.st <= rdw_pkg::ST_IDLE;
      s_reg.start_off <= rdw_pkg::START_OFFSET_RST;
      s_reg.keep <= rdw_pkg::FILTER_ENABLE_RST;
      s_reg.max_len <= rdw_pkg::MAX_LEN_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign mem_req = s_reg.mem_req;
  assign mem_we = s_reg.mem_we;
  assign mem_addr = s_reg.mem_addr;
  assign mem_be = s_reg.mem_be;
  assign mem_wdata = s_reg.mem_wdata;
  assign pkt_ready = s_reg.pkt_ready;
  assign chan_running = s_reg.running;

endmodule

`default_nettype wire

// File: rdw_pkg.sv
// Constants and types for the receive descriptor write-back engine.
// Assumes a 32-bit APB register port and a 32-bit word memory port.
package rdw_pkg;

  // Register byte offsets on the APB port
  localparam logic [7:0] REG_HEAD_PTR = 8'h00;
  localparam logic [7:0] REG_START_OFFSET = 8'h04;
  localparam logic [7:0] REG_FILTER_ENABLE = 8'h08;
  localparam logic [7:0] REG_MAX_LEN = 8'h0C;
  localparam logic [7:0] REG_TEARDOWN = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_CUR_DESC = 8'h18;

  // Reset values
  localparam logic [15:0] START_OFFSET_RST = 16'h0000;
  localparam logic [3:0] FILTER_ENABLE_RST = 4'h0;
  localparam logic [15:0] MAX_LEN_RST = 16'h05EE;

  // Keep-enable bit positions in the filter enable register
  localparam int KEEP_ERROR = 0;
  localparam int KEEP_SHORT = 1;
  localparam int KEEP_CONTROL = 2;
  localparam int KEEP_ALL = 3;

  // Status register bit positions
  localparam int STAT_RUNNING = 0;
  localparam int STAT_TD_DONE = 1;

  // Descriptor word byte offsets
  localparam logic [31:0] DESC_NEXT = 32'h0000_0000;
  localparam logic [31:0] DESC_BUF = 32'h0000_0004;
  localparam logic [31:0] DESC_OFFLEN = 32'h0000_0008;
  localparam logic [31:0] DESC_FLAGLEN = 32'h0000_000C;

  // Flag bit positions in the flags/length word
  localparam int FLG_FIRST = 31;
  localparam int FLG_LAST = 30;
  localparam int FLG_OWNERSHIP_FLAG = 29;
  localparam int FLG_EOQ = 28;
  localparam int FLG_TEARDOWN = 27;
  localparam int FLG_CRC_INC = 26;
  localparam int FLG_JABBER = 25;
  localparam int FLG_OVERSIZE = 24;
  localparam int FLG_FRAGMENT = 23;
  localparam int FLG_UNDERSIZED = 22;
  localparam int FLG_CONTROL = 21;
  localparam int FLG_OVERRUN = 20;
  localparam int FLG_CODE_ERR = 19;
  localparam int FLG_ALIGN_ERR = 18;
  localparam int FLG_CRC_ERR = 17;
  localparam int FLG_ADDR_MISS = 16;

  // Engine states, Gray coded in declaration order
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_RD_NEXT = 4'h1,
    ST_RD_BUF = 4'h3,
    ST_RD_LEN = 4'h2,
    ST_WAIT_BYTE = 4'h6,
    ST_WR_BYTE = 4'h7,
    ST_WB_LEN = 4'h5,
    ST_WB_FLAGS = 4'h4,
    ST_WB_FIRST = 4'hC,
    ST_TEARDOWN = 4'hD
  } rdw_state_t;

endpackage

// File: rdw_engine_properties.sv
// Port-level checks for the receive descriptor write-back engine.
// Assumes descriptors sit on 16-byte boundaries in memory.
`timescale 1ns/100ps
`default_nettype none
module rdw_engine_properties (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // APB slave side
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Memory master side
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [3:0] mem_be,
  input wire logic [31:0] mem_wdata,
  input wire logic mem_ack,
  // Stream and channel
  input wire logic pkt_ready,
  input wire logic chan_running
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  wire bad_a = (paddr > 8'h18) || (paddr[1:0] != 2'b00);
  wire desc_wr = mem_req && mem_we && (mem_be == 4'hF);
  wire flag_wr = desc_wr && (mem_addr[3:0] == 4'hC);
  wire fst = mem_wdata[rdw_pkg::FLG_FIRST];
  wire tdn = mem_wdata[rdw_pkg::FLG_TEARDOWN];
  sequence s_access; psel && penable && !pready; endsequence
  sequence s_stop; flag_wr && mem_ack && (mem_wdata[rdw_pkg::FLG_EOQ] || tdn); endsequence
  property p_apb_wait; s_access |=> pready ##1 !pready; endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("apb answer timing wrong");
  property p_apb_err; pready |-> (pslverr == bad_a) && (!pslverr || prdata == 32'h0); endproperty
  a_apb_err: assert property (p_apb_err) else $error("apb error response wrong");
  property p_req_hold; mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_wdata); endproperty
  a_req_hold: assert property (p_req_hold) else $error("memory request not held");
  property p_next_ro; desc_wr |-> mem_addr[3:0] != 4'h0 && mem_addr[3:0] != 4'h4; endproperty
  a_next_ro: assert property (p_next_ro) else $error("pointer word written");
  property p_ownership_flag; flag_wr && !tdn |-> mem_wdata[rdw_pkg::FLG_OWNERSHIP_FLAG] != fst; endproperty
  a_ownership_flag: assert property (p_ownership_flag) else $error("ownership released off first");
  property p_pktlen; flag_wr && !fst |-> mem_wdata[15:0] == 16'h0000; endproperty
  a_pktlen: assert property (p_pktlen) else $error("packet length off first");
  property p_eoq_last; flag_wr && mem_wdata[rdw_pkg::FLG_EOQ] |-> mem_wdata[rdw_pkg::FLG_LAST]; endproperty
  a_eoq_last: assert property (p_eoq_last) else $error("queue end without last");
  property p_stop; s_stop |-> ##[1:60] !chan_running; endproperty
  a_stop: assert property (p_stop) else $error("channel did not halt");
  property p_td_word; flag_wr && tdn |-> mem_wdata == 32'h0800_0000; endproperty
  a_td_word: assert property (p_td_word) else $error("teardown word wrong");
  property p_halted; !chan_running && $past(!chan_running) |-> !pkt_ready; endproperty
  a_halted: assert property (p_halted) else $error("bytes taken while halted");
endmodule
bind rdw_engine rdw_engine_properties rdw_engine_properties_i (.clk_sys(clk_sys), .rstn(rstn),
  .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
  .mem_be(mem_be), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .pkt_ready(pkt_ready),
  .chan_running(chan_running));
`default_nettype wire

// File: rdw_mem_model.sv
// Shared descriptor and buffer memory, answering lat+1 cycles after a request.
// Assumes one outstanding request and addresses below 0x400.
`timescale 1ns/100ps
`default_nettype none
module rdw_mem_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Memory port
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [3:0] mem_be,
  input wire logic [31:0] mem_wdata,
  output logic mem_ack,
  output logic [31:0] mem_rdata,
  // Answer delay
  input wire logic [3:0] lat
);
  logic [31:0] ram [0:255];
  logic [3:0] cnt = 4'h0;
  always @(posedge clk_sys) begin
    mem_ack <= 1'b0;
    // Idle data bus toggles so stale data is never mistaken for an answer
    mem_rdata <= ~mem_rdata;
    if (!rstn) begin
      cnt <= 4'h0;
      mem_rdata <= 32'h0;
    end else if (mem_req && !mem_ack) begin
      if (cnt < lat) begin
        cnt <= cnt + 4'h1;
      end else begin
        cnt <= 4'h0;
        mem_ack <= 1'b1;
        if (!mem_we) begin
          mem_rdata <= ram[mem_addr[9:2]];
        end
        for (int b = 0; b < 4; b++) begin
          if (mem_we && mem_be[b]) begin
            ram[mem_addr[9:2]][8*b +: 8] <= mem_wdata[8*b +: 8];
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: testbench.sv
// Self-checking bench: APB set-up, byte stream packets, descriptor checks.
// Assumes the memory model stands for software's descriptor memory.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pkt_valid = 1'b0, pkt_last = 1'b0;
  logic [7:0] paddr = 8'h00, pkt_byte = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, mem_addr, mem_wdata, mem_rdata, q;
  logic pready, pslverr, mem_req, mem_we, mem_ack, pkt_ready, chan_running, e;
  logic [3:0] mem_be;
  logic [3:0] lat = 4'h0;
  logic [8:0] st = 9'h000;
  int bad_count = 0;
  int checks = 0;
  rdw_engine rdw_engine_i (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_be(mem_be), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .pkt_valid(pkt_valid), .pkt_byte(pkt_byte), .pkt_last(pkt_last), .pkt_ready(pkt_ready),
    .pkt_crc_included(st[8]), .pkt_crc_err(st[7]), .pkt_code_err(st[6]),
    .pkt_align_err(st[5]), .pkt_fragment(st[4]), .pkt_undersized(st[3]),
    .pkt_control(st[2]), .pkt_overrun(st[1]), .pkt_addr_miss(st[0]),
    .chan_running(chan_running));
  rdw_mem_model rdw_mem_model_i (.clk_sys(clk_sys), .rstn(rstn), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_be(mem_be), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .lat(lat));
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // No assumed wait count: only the watchdog ends a hung access
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic ex);
    apb(a, 1'b0, 32'h0);
    chk(q, exp);
    chk({31'h0, e}, {31'h0, ex});
  endtask
  task automatic mk(input int a, input logic [31:0] nx, input logic [31:0] bp);
    rdw_mem_model_i.ram[a/4] = nx;
    rdw_mem_model_i.ram[a/4+1] = bp;
    rdw_mem_model_i.ram[a/4+2] = 32'h0000_0008;
    rdw_mem_model_i.ram[a/4+3] = 32'h2000_0000;
  endtask
  task automatic send(input int len, input logic [8:0] s);
    st <= s;
    for (int i = 0; i < len; i++) begin
      pkt_valid <= 1'b1;
      pkt_byte <= 8'hA0 + i[7:0];
      pkt_last <= (i == len - 1);
      do begin
        @(posedge clk_sys);
      end while (pkt_ready !== 1'b1);
    end
    pkt_valid <= 1'b0;
    pkt_last <= 1'b0;
  endtask
  task automatic wait_own(input int a);
    while (rdw_mem_model_i.ram[a/4+3][rdw_pkg::FLG_OWNERSHIP_FLAG] !== 1'b0) begin
      @(posedge clk_sys);
    end
    while (chan_running === 1'b1 && a >= 32'h1B0) begin
      @(posedge clk_sys);
    end
  endtask
  function automatic logic [31:0] fl(input logic [8:0] s);
    fl = {5'h00, s[8], 2'h0, s[4:3], s[2], s[1], s[6], s[5], s[7], s[0], 16'h0};
  endfunction
  initial begin
    logic [8:0] s;
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    rd(rdw_pkg::REG_START_OFFSET, 32'h0, 1'b0);
    rd(rdw_pkg::REG_FILTER_ENABLE, 32'h0, 1'b0);
    rd(rdw_pkg::REG_MAX_LEN, 32'h0000_05EE, 1'b0);
    rd(8'h1C, 32'h0, 1'b1);
    rd(8'h05, 32'h0, 1'b1);
    apb(rdw_pkg::REG_START_OFFSET, 1'b1, 32'h3);
    apb(rdw_pkg::REG_FILTER_ENABLE, 1'b1, 32'hF);
    apb(rdw_pkg::REG_MAX_LEN, 1'b1, 32'h9);
    rd(rdw_pkg::REG_MAX_LEN, 32'h9, 1'b0);
    for (int i = 0; i < 12; i++) mk(256 + 16 * i, (i == 11) ? 0 : 272 + 16 * i, 512 + 8 * i);
    apb(rdw_pkg::REG_HEAD_PTR, 1'b1, 32'h100);
    rd(rdw_pkg::REG_STATUS, 32'h1, 1'b0);
    // Two-buffer packet, offset only in the first buffer
    send(10, 9'h100);
    wait_own(32'h100);
    chk(rdw_mem_model_i.ram[66], 32'h0003_0005);
    chk(rdw_mem_model_i.ram[67], 32'h8500_000A);
    chk(rdw_mem_model_i.ram[70], 32'h0000_0005);
    chk(rdw_mem_model_i.ram[71], 32'h6000_0000);
    // Second buffer starts right where the first one ends, so bytes run on
    for (int i = 0; i < 10; i++) begin
      chk(rdw_mem_model_i.ram[(515 + i) / 4][8 * ((515 + i) % 4) +: 8],
        8'hA0 + i[7:0]);
    end
    // One status cause per packet, slow memory, all overlong
    apb(rdw_pkg::REG_MAX_LEN, 1'b1, 32'h3);
    lat <= 4'h3;
    for (int k = 0; k < 9; k++) begin
      s = 9'h001 << k;
      send(4, s);
      wait_own(288 + 16 * k);
      chk(rdw_mem_model_i.ram[74+4*k], 32'h0003_0004);
      chk(rdw_mem_model_i.ram[75+4*k], 32'hC000_0004 | fl(s) | ((s[7:5] != 3'h0) ?
        32'h0200_0000 : 32'h0100_0000));
    end
    // Keep bits off: only overrun and crc-included survive, queue ends
    apb(rdw_pkg::REG_FILTER_ENABLE, 1'b1, 32'h0);
    send(4, 9'h1FF);
    wait_own(32'h1B0);
    chk(rdw_mem_model_i.ram[111], 32'hD410_0004);
    rd(rdw_pkg::REG_STATUS, 32'h0, 1'b0);
    chk(rdw_mem_model_i.ram[64], 32'h0000_0110);
    apb(rdw_pkg::REG_TEARDOWN, 1'b1, 32'h1);
    rd(rdw_pkg::REG_STATUS, 32'h2, 1'b0);
    apb(rdw_pkg::REG_STATUS, 1'b1, 32'h2);
    rd(rdw_pkg::REG_STATUS, 32'h0, 1'b0);
    // Teardown of a running queue marks the free descriptor
    mk(32'h1C0, 32'h0, 32'h280);
    apb(rdw_pkg::REG_HEAD_PTR, 1'b1, 32'h1C0);
    apb(rdw_pkg::REG_TEARDOWN, 1'b1, 32'h1);
    wait_own(32'h1C0);
    chk(rdw_mem_model_i.ram[115], 32'h0800_0000);
    rd(rdw_pkg::REG_STATUS, 32'h2, 1'b0);
    end_of_test();
  end
  initial begin
    repeat (30000) @(posedge clk_sys);
    bad_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
